// ---- tlpt_consts.vh ----
// Constants shared by the two-level page translation block
`ifndef TLPT_CONSTS_VH
`define TLPT_CONSTS_VH
// ----------------------------------------------------------------------------
// Register map (byte addresses on the slave port)
// ----------------------------------------------------------------------------
`define TLPT_ADDR_W 5
`define TLPT_REG_CTRL 5'h00
`define TLPT_REG_DIR_BASE 5'h04
`define TLPT_REG_STATUS 5'h08
`define TLPT_REG_MASK 5'h0c
`define TLPT_REG_FAULT_ADDR 5'h10
`define TLPT_CTRL_ENABLE 0
`define TLPT_CTRL_RESET 32'h0000_0000
`define TLPT_EVT_W 3
`define TLPT_EVT_FAULT 0
`define TLPT_EVT_PTE_ERR 1
`define TLPT_EVT_DENIED 2
// ----------------------------------------------------------------------------
// Graphics address split and entry layouts
// ----------------------------------------------------------------------------
`define TLPT_DIR_IDX_HI 31
`define TLPT_DIR_IDX_LO 22
`define TLPT_TBL_IDX_HI 21
`define TLPT_TBL_IDX_LO 12
`define TLPT_OFS_HI 11
`define TLPT_BIG_LO 15
`define TLPT_BIG_STEP_MASK 10'h3f8
`define TLPT_PAGE_HI 31
`define TLPT_PAGE_LO 12
`define TLPT_EXT_HI 11
`define TLPT_EXT_LO 4
`define TLPT_PDE_SIZE 1
`define TLPT_PDE_VALID 0
`define TLPT_PTE_GRAPHICS_DATA_TYPE_FLAG 3
`define TLPT_PTE_CC_HI 2
`define TLPT_PTE_CC_LO 1
`define TLPT_PTE_VALID 0
`define TLPT_CC_NONE 2'b01
`define TLPT_CC_LLC 2'b10
`define TLPT_CC_BOTH 2'b11
`endif

// ---- tlpt_avmm_regs.v ----
// Avalon-MM register slave with sticky events, mask and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "tlpt_consts.vh"
module tlpt_avmm_regs (
  input wire clk,
  input wire rst,
  input wire [`TLPT_ADDR_W-1:0] avsAddress,
  input wire avsRead,
  input wire avsWrite,
  input wire [31:0] avsWriteData,
  input wire [3:0] avsByteEnable,
  output reg [31:0] avsReadData,
  output wire avsWaitRequest,
  output wire transEnable,
  output wire [19:0] dirBase,
  output wire cfgFlush,
  input wire [`TLPT_EVT_W-1:0] evPulse,
  input wire evLoad,
  input wire [31:0] evAddr,
  output wire irq
);
  reg ack;
  reg [31:0] ctrl;
  reg [31:0] dirReg;
  reg [31:0] faultAddr;
  reg [`TLPT_EVT_W-1:0] status;
  reg [`TLPT_EVT_W-1:0] mask;
  wire req = avsRead | avsWrite;
  wire wrDone = avsWrite & ack;
  wire [31:0] byteMask = {{8{avsByteEnable[3]}}, {8{avsByteEnable[2]}},
                          {8{avsByteEnable[1]}}, {8{avsByteEnable[0]}}};
  wire [31:0] merged = avsWriteData & byteMask;
  wire [`TLPT_EVT_W-1:0] clrBits = (wrDone && avsAddress == `TLPT_REG_STATUS) ?
                                   merged[`TLPT_EVT_W-1:0] : {`TLPT_EVT_W{1'b0}};

  function [31:0] mergeBytes;
    input [31:0] old;
    input [31:0] wd;
    input [31:0] bm;
    begin
      mergeBytes = (old & ~bm) | (wd & bm);
    end
  endfunction

  // One wait cycle per access; read data is captured while waitrequest is high
  assign avsWaitRequest = req & ~ack;
  assign transEnable = ctrl[`TLPT_CTRL_ENABLE];
  assign dirBase = dirReg[`TLPT_PAGE_HI:`TLPT_PAGE_LO];
  // Any change of enable or directory base drops every cached entry
  assign cfgFlush = wrDone && (avsAddress == `TLPT_REG_CTRL || avsAddress == `TLPT_REG_DIR_BASE);
  assign irq = |(status & mask);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
      avsReadData <= 32'h0000_0000;
      ctrl <= `TLPT_CTRL_RESET;
      dirReg <= 32'h0000_0000;
      mask <= {`TLPT_EVT_W{1'b0}};
      status <= {`TLPT_EVT_W{1'b0}};
      faultAddr <= 32'h0000_0000;
    end else begin
      ack <= req & ~ack;
      if (avsRead && !ack) begin
        case (avsAddress)
          `TLPT_REG_CTRL: avsReadData <= ctrl;
          `TLPT_REG_DIR_BASE: avsReadData <= dirReg;
          `TLPT_REG_STATUS: avsReadData <= {{(32-`TLPT_EVT_W){1'b0}}, status};
          `TLPT_REG_MASK: avsReadData <= {{(32-`TLPT_EVT_W){1'b0}}, mask};
          `TLPT_REG_FAULT_ADDR: avsReadData <= faultAddr;
          default: avsReadData <= 32'h0000_0000;
        endcase
      end
      if (wrDone) begin
        case (avsAddress)
          `TLPT_REG_CTRL: ctrl <= mergeBytes(ctrl, avsWriteData, byteMask) & 32'h0000_0001;
          `TLPT_REG_DIR_BASE: dirReg <= mergeBytes(dirReg, avsWriteData, byteMask) & 32'hffff_f000;
          `TLPT_REG_MASK: mask <= merged[`TLPT_EVT_W-1:0] |
                                  (mask & ~byteMask[`TLPT_EVT_W-1:0]);
          default: ;
        endcase
      end
      // A new event in the clearing cycle stays set
      status <= (status & ~clrBits) | evPulse;
      if (evLoad) begin
        faultAddr <= evAddr;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tlpt_tlb.v ----
// Direct-mapped translation buffer for 4KB and 32KB page entries
`timescale 1ns/1ps
`default_nettype none
`include "tlpt_consts.vh"
module tlpt_tlb #(
  parameter IDX_W = 3
) (
  input wire clk,
  input wire rst,
  input wire flush,
  input wire [31:0] lookupAddr,
  output wire hit,
  output wire [27:0] hitPpn,
  output wire hitBig,
  output wire hitGfdt,
  output wire [1:0] hitCc,
  input wire fillEn,
  input wire [31:0] fillAddr,
  input wire fillBig,
  input wire [27:0] fillPpn,
  input wire fillGfdt,
  input wire [1:0] fillCc
);
  localparam DEPTH = 1 << IDX_W;
  reg [DEPTH-1:0] vld;
  reg [DEPTH-1:0] big;
  reg [19:0] tag [0:DEPTH-1];
  reg [27:0] ppn [0:DEPTH-1];
  reg [DEPTH-1:0] graphics_data_type_flag;
  reg [1:0] cc [0:DEPTH-1];
  integer i;

  // Slot taken from bit 15 upward so one 32KB page owns a single slot
  function [IDX_W-1:0] slotOf;
    input [31:0] a;
    begin
      slotOf = a[`TLPT_BIG_LO +: IDX_W];
    end
  endfunction

  wire [IDX_W-1:0] ls = slotOf(lookupAddr);
  wire [IDX_W-1:0] fs = slotOf(fillAddr);
  wire [19:0] lt = lookupAddr[`TLPT_PAGE_HI:`TLPT_PAGE_LO];
  // Big entries compare bits 15 and up only
  wire tagOk = big[ls] ? (tag[ls][19:3] == lt[19:3]) : (tag[ls] == lt);
  assign hit = vld[ls] & tagOk;
  assign hitPpn = ppn[ls];
  assign hitBig = big[ls];
  assign hitGfdt = graphics_data_type_flag[ls];
  assign hitCc = cc[ls];

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      vld <= {DEPTH{1'b0}};
      big <= {DEPTH{1'b0}};
      graphics_data_type_flag <= {DEPTH{1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        tag[i] <= 20'h00000;
        ppn[i] <= 28'h0000000;
        cc[i] <= 2'b00;
      end
    end else if (flush) begin
      vld <= {DEPTH{1'b0}};
    end else if (fillEn) begin
      vld[fs] <= 1'b1;
      big[fs] <= fillBig;
      graphics_data_type_flag[fs] <= fillGfdt;
      tag[fs] <= fillAddr[`TLPT_PAGE_HI:`TLPT_PAGE_LO];
      ppn[fs] <= fillPpn;
      cc[fs] <= fillCc;
    end
  end
endmodule
`default_nettype wire

// ---- tlpt_translate.v ----
// Two-level per-process translation engine with register slave and buffer
//
// The Avalon-MM interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "tlpt_consts.vh"
module tlpt_translate #(
  parameter TLB_IDX_W = 3
) (
  input wire clk,
  input wire rst,
  // Register slave
  input wire [`TLPT_ADDR_W-1:0] avsAddress,
  input wire avsRead,
  input wire avsWrite,
  input wire [31:0] avsWriteData,
  input wire [3:0] avsByteEnable,
  output wire [31:0] avsReadData,
  output wire avsWaitRequest,
  output wire irq,
  // Client request
  input wire reqValid,
  output wire reqReady,
  input wire [31:0] reqAddr,
  input wire reqWrite,
  input wire reqCpuRead,
  input wire reqMemIfCmd,
  input wire reqGlobal,
  input wire reqPrivSource,
  input wire reqStateDataType,
  // Translated answer
  output wire respValid,
  input wire respReady,
  output reg [39:0] respAddr,
  output reg respGlobal,
  output reg respDataType,
  output reg respLlc,
  output reg respMlc,
  output reg respPageFault,
  output reg respTableError,
  output reg respDenied,
  // Entry fetch port
  output wire memRdValid,
  input wire memRdReady,
  output reg [39:0] memRdAddr,
  output reg memRdGlobal,
  input wire memRspValid,
  input wire [31:0] memRspData
);
  // --------------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------------
  localparam ST_IDLE = 3'd0;
  localparam ST_PDE_REQ = 3'd1;
  localparam ST_PDE_WAIT = 3'd2;
  localparam ST_PTE_REQ = 3'd3;
  localparam ST_PTE_WAIT = 3'd4;
  localparam ST_RESP = 3'd5;

  reg [2:0] state;
  reg [31:0] va;
  reg isWrite;
  reg isCpuRead;
  reg stateDt;
  reg pdeCacheValid;
  reg [9:0] pdeCacheIdx;
  reg [31:0] pdeCache;
  reg [31:0] curPde;
  reg [`TLPT_EVT_W-1:0] evPulse;
  reg evLoad;

  wire transEnable;
  wire [19:0] dirBase;
  wire cfgFlush;
  wire tlbHit;
  wire [27:0] tlbPpn;
  wire tlbBig;
  wire tlbGfdt;
  wire [1:0] tlbCc;
  // Fill at the response edge, while the entry word is still on the bus
  wire tlbFill = (state == ST_PTE_WAIT) && memRspValid && memRspData[`TLPT_PTE_VALID] && !cfgFlush;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function [9:0] dirIdx;
    input [31:0] a;
    begin
      dirIdx = a[`TLPT_DIR_IDX_HI:`TLPT_DIR_IDX_LO];
    end
  endfunction

  // Entry word address inside a 4KB structure; each structure is one page
  function [39:0] entryAddr;
    input [7:0] ext;
    input [19:0] page;
    input [9:0] idx;
    begin
      entryAddr = {ext, page, idx, 2'b00};
    end
  endfunction

  // Final physical address; big pages keep offset bits 14:0
  function [39:0] physOf;
    input [27:0] ppn;
    input big;
    input [31:0] a;
    begin
      if (big) begin
        physOf = {ppn[27:3], a[`TLPT_BIG_LO-1:0]};
      end else begin
        physOf = {ppn, a[`TLPT_OFS_HI:0]};
      end
    end
  endfunction

  function [27:0] ppnOf;
    input [31:0] e;
    begin
      ppnOf = {e[`TLPT_EXT_HI:`TLPT_EXT_LO], e[`TLPT_PAGE_HI:`TLPT_PAGE_LO]};
    end
  endfunction

  // --------------------------------------------------------------------------
  // Submodules
  // --------------------------------------------------------------------------
  tlpt_avmm_regs u_regs (
    .clk(clk),
    .rst(rst),
    .avsAddress(avsAddress),
    .avsRead(avsRead),
    .avsWrite(avsWrite),
    .avsWriteData(avsWriteData),
    .avsByteEnable(avsByteEnable),
    .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest),
    .transEnable(transEnable),
    .dirBase(dirBase),
    .cfgFlush(cfgFlush),
    .evPulse(evPulse),
    .evLoad(evLoad),
    .evAddr(va),
    .irq(irq)
  );

  wire pteValid = memRspData[`TLPT_PTE_VALID];
  wire curBig = curPde[`TLPT_PDE_SIZE];

  tlpt_tlb #(
    .IDX_W(TLB_IDX_W)
  ) u_tlb (
    .clk(clk),
    .rst(rst),
    .flush(cfgFlush),
    .lookupAddr(reqAddr),
    .hit(tlbHit),
    .hitPpn(tlbPpn),
    .hitBig(tlbBig),
    .hitGfdt(tlbGfdt),
    .hitCc(tlbCc),
    .fillEn(tlbFill),
    .fillAddr(va),
    .fillBig(curBig),
    .fillPpn(ppnOf(memRspData)),
    .fillGfdt(memRspData[`TLPT_PTE_GRAPHICS_DATA_TYPE_FLAG]),
    .fillCc(memRspData[`TLPT_PTE_CC_HI:`TLPT_PTE_CC_LO])
  );

  // --------------------------------------------------------------------------
  // Handshakes
  // --------------------------------------------------------------------------
  assign reqReady = (state == ST_IDLE);
  assign respValid = (state == ST_RESP);
  assign memRdValid = (state == ST_PDE_REQ) || (state == ST_PTE_REQ);

  wire take = reqValid & reqReady;
  wire reqDirHit = pdeCacheValid && (pdeCacheIdx == dirIdx(reqAddr));
  // Memory interface command requests and disabled translation bypass the tables
  wire useGlobal = reqMemIfCmd | ~transEnable;
  wire grantOk = ~reqGlobal | reqPrivSource;
  // Big tables are indexed at multiples of eight only
  wire [9:0] tblIdx = curBig ? (va[`TLPT_TBL_IDX_HI:`TLPT_TBL_IDX_LO] & `TLPT_BIG_STEP_MASK) :
                      va[`TLPT_TBL_IDX_HI:`TLPT_TBL_IDX_LO];

  // --------------------------------------------------------------------------
  // Walk sequencer
  // --------------------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      va <= 32'h0000_0000;
      isWrite <= 1'b0;
      isCpuRead <= 1'b0;
      stateDt <= 1'b0;
      pdeCacheValid <= 1'b0;
      pdeCacheIdx <= 10'h000;
      pdeCache <= 32'h0000_0000;
      curPde <= 32'h0000_0000;
      memRdAddr <= 40'h00_0000_0000;
      memRdGlobal <= 1'b0;
      respAddr <= 40'h00_0000_0000;
      respGlobal <= 1'b0;
      respDataType <= 1'b0;
      respLlc <= 1'b0;
      respMlc <= 1'b0;
      respPageFault <= 1'b0;
      respTableError <= 1'b0;
      respDenied <= 1'b0;
      evPulse <= {`TLPT_EVT_W{1'b0}};
      evLoad <= 1'b0;
    end else begin
      evPulse <= {`TLPT_EVT_W{1'b0}};
      evLoad <= 1'b0;
      // Cached directory entries are dropped on reconfiguration only
      if (cfgFlush) begin
        pdeCacheValid <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          if (take) begin
            va <= reqAddr;
            isWrite <= reqWrite;
            isCpuRead <= reqCpuRead;
            stateDt <= reqStateDataType;
            respPageFault <= 1'b0;
            respTableError <= 1'b0;
            respDenied <= 1'b0;
            respLlc <= 1'b0;
            respMlc <= 1'b0;
            respDataType <= reqWrite & reqStateDataType;
            if (reqMemIfCmd && !grantOk) begin
              respDenied <= 1'b1;
              respGlobal <= 1'b1;
              respAddr <= 40'h00_0000_0000;
              evPulse[`TLPT_EVT_DENIED] <= 1'b1;
              evLoad <= 1'b1;
              state <= ST_RESP;
            end else if (useGlobal) begin
              // Global table outside resolves the address
              respGlobal <= 1'b1;
              respAddr <= {8'h00, reqAddr};
              state <= ST_RESP;
            end else if (tlbHit && !cfgFlush) begin
              respGlobal <= 1'b0;
              respAddr <= physOf(tlbPpn, tlbBig, reqAddr);
              respDataType <= reqWrite & (tlbGfdt | reqStateDataType);
              respLlc <= tlbCc[1];
              respMlc <= (tlbCc == `TLPT_CC_BOTH);
              state <= ST_RESP;
            end else if (reqDirHit && !cfgFlush) begin
              respGlobal <= 1'b0;
              curPde <= pdeCache;
              state <= ST_PTE_REQ;
            end else begin
              respGlobal <= 1'b0;
              // Directory words are fetched through the global table
              memRdAddr <= entryAddr(8'h00, dirBase, dirIdx(reqAddr));
              memRdGlobal <= 1'b1;
              state <= ST_PDE_REQ;
            end
          end
        end
        ST_PDE_REQ: begin
          if (memRdReady) begin
            state <= ST_PDE_WAIT;
          end
        end
        ST_PDE_WAIT: begin
          if (memRspValid) begin
            // Reserved bits 3:2 are not checked
            curPde <= memRspData;
            if (!memRspData[`TLPT_PDE_VALID]) begin
              respPageFault <= 1'b1;
              evPulse[`TLPT_EVT_FAULT] <= 1'b1;
              evLoad <= 1'b1;
              state <= ST_RESP;
            end else begin
              pdeCacheValid <= ~cfgFlush;
              pdeCacheIdx <= dirIdx(va);
              pdeCache <= memRspData;
              state <= ST_PTE_REQ;
            end
          end
        end
        ST_PTE_REQ: begin
          // Tables are in plain unsnooped memory, not the global table
          memRdAddr <= entryAddr(curPde[`TLPT_EXT_HI:`TLPT_EXT_LO],
                                 curPde[`TLPT_PAGE_HI:`TLPT_PAGE_LO], tblIdx);
          memRdGlobal <= 1'b0;
          if (memRdReady && memRdValid && memRdGlobal == 1'b0 &&
              memRdAddr == entryAddr(curPde[`TLPT_EXT_HI:`TLPT_EXT_LO],
                                     curPde[`TLPT_PAGE_HI:`TLPT_PAGE_LO], tblIdx)) begin
            state <= ST_PTE_WAIT;
          end
        end
        ST_PTE_WAIT: begin
          if (memRspValid) begin
            respAddr <= physOf(ppnOf(memRspData), curBig, va);
            respDataType <= isWrite & (memRspData[`TLPT_PTE_GRAPHICS_DATA_TYPE_FLAG] | stateDt);
            respLlc <= memRspData[`TLPT_PTE_CC_HI];
            respMlc <= (memRspData[`TLPT_PTE_CC_HI:`TLPT_PTE_CC_LO] == `TLPT_CC_BOTH);
            if (!pteValid && !isCpuRead) begin
              respTableError <= 1'b1;
              evPulse[`TLPT_EVT_PTE_ERR] <= 1'b1;
              evLoad <= 1'b1;
            end
            state <= ST_RESP;
          end
        end
        ST_RESP: begin
          if (respReady) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- tlpt_translate_checker.sv ----
// Assertion checker for the two-level page translation block
`timescale 1ns/1ps
`default_nettype none
module tlpt_translate_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic reqValid,
  input wire logic reqReady,
  input wire logic [31:0] reqAddr,
  input wire logic reqCpuRead,
  input wire logic reqMemIfCmd,
  input wire logic reqGlobal,
  input wire logic reqPrivSource,
  input wire logic respValid,
  input wire logic [39:0] respAddr,
  input wire logic respGlobal,
  input wire logic respLlc,
  input wire logic respMlc,
  input wire logic respPageFault,
  input wire logic respTableError,
  input wire logic respDenied,
  input wire logic memRdValid,
  input wire logic memRdReady,
  input wire logic [39:0] memRdAddr,
  input wire logic memRdGlobal,
  input wire logic memRspValid,
  input wire logic [31:0] memRspData
);
  // ----------
  // Walk state seen at the ports
  // ----------
  logic [31:0] va, directory_entry, table_entry;
  logic cpu, fg;
  wire logic [39:0] pteAddr, physAddr;
  assign pteAddr = {directory_entry[11:4], directory_entry[31:12], directory_entry[1] ? {va[21:15], 3'h0} : va[21:12], 2'h0};
  assign physAddr = directory_entry[1] ? {table_entry[11:4], table_entry[31:15], va[14:0]} : {table_entry[11:4], table_entry[31:12], va[11:0]};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {va, directory_entry, table_entry, cpu, fg} <= '0;
    end else begin
      if (reqValid && reqReady) begin
        va <= reqAddr;
        cpu <= reqCpuRead;
      end
      if (memRdValid && memRdReady)
        fg <= memRdGlobal;
      // Only a valid directory word can be reused from the directory cache
      if (memRspValid && fg && memRspData[0])
        directory_entry <= memRspData;
      if (memRspValid && !fg)
        table_entry <= memRspData;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_take; reqValid && reqReady; endsequence
  sequence s_pte_in; memRspValid && !fg; endsequence
  sequence s_pte_used; s_pte_in ##0 (memRspData[0] || cpu); endsequence
  a_deny_unpriv: assert property (s_take ##0 (reqMemIfCmd && reqGlobal && !reqPrivSource) |=>
    respValid && respDenied && respAddr == 40'h0) else $error("unprivileged global access passed");
  a_memif_global: assert property (s_take ##0 (reqMemIfCmd && !(reqGlobal && !reqPrivSource))
    |=> respValid && respGlobal && !respDenied && respAddr == {8'h00, va}) else $error("bad bypass");
  a_dir_index: assert property (memRdValid && memRdReady && memRdGlobal |->
    memRdAddr[11:0] == {va[31:22], 2'h0}) else $error("bad directory index");
  a_tbl_addr: assert property (memRdValid && memRdReady && !memRdGlobal |->
    memRdAddr == pteAddr) else $error("bad table entry address");
  a_dir_fault: assert property (memRspValid && fg && !memRspData[0] |->
    ##[1:2] respValid && respPageFault) else $error("invalid directory entry without fault");
  a_tbl_error: assert property (s_pte_in ##0 !memRspData[0] |->
    ##[1:2] respValid && respTableError == !cpu) else $error("wrong table entry error");
  a_tbl_phys: assert property (s_pte_used |->
    ##[1:2] respValid && respAddr == physAddr) else $error("wrong physical address");
  a_tbl_cache: assert property (s_pte_used |->
    ##[1:2] respValid && respLlc == table_entry[2] && respMlc == (table_entry[2] && table_entry[1])) else $error("bad cc");
endmodule
`default_nettype wire

// ---- tlpt_mem_model.sv ----
// Behavioural main memory answering directory and table entry fetches
`timescale 1ns/1ps
`default_nettype none
module tlpt_mem_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic memRdValid,
  output logic memRdReady,
  input wire logic [39:0] memRdAddr,
  input wire logic memRdGlobal,
  output logic memRspValid,
  output logic [31:0] memRspData
);
  // ----------
  // Entry store and fetch handshake
  // ----------
  // Directory and tables are single 4K pages anywhere in one flat store
  logic [31:0] words [logic [39:0]];
  integer seed = 11;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      memRdReady <= 1'b0;
      memRspValid <= 1'b0;
      memRspData <= 32'h0;
    end else begin
      // Never ready in the first valid cycle, so a stale address is never taken
      memRdReady <= memRdValid && !memRdReady && ($random(seed) & 3) != 0;
      memRspValid <= memRdValid && memRdReady;
      // Directory words sit in the same store as the global space
      if (memRdValid && memRdReady)
        memRspData <= words.exists(memRdAddr) ? words[memRdAddr] : 32'h0;
      else
        memRspData <= ~memRspData;
    end
  end
endmodule
`default_nettype wire

// ---- tlpt_translate_test.sv ----
// Self-checking testbench for the two-level page translation block
`timescale 1ns/1ps
`default_nettype none
`include "tlpt_consts.vh"
module tlpt_translate_test;
  // ----------
  // Design, partner and scoreboard
  // ----------
  typedef struct packed {logic [46:0] v; logic [46:0] m;} tlpt_note_t;
  localparam logic [46:0] ALL = '1;
  localparam logic [46:0] BYP = 47'h7fff_ffff_ffe7;
  localparam logic [46:0] FLG = 47'h7;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] avsAddress = 5'h00;
  logic avsRead = 1'b0, avsWrite = 1'b0, reqValid = 1'b0, respReady = 1'b0;
  logic [31:0] avsWriteData = 32'h0, reqAddr = 32'h0;
  logic [3:0] avsByteEnable = 4'hf;
  logic reqWrite = 1'b0, reqCpuRead = 1'b0, reqMemIfCmd = 1'b0, reqGlobal = 1'b0;
  logic reqPrivSource = 1'b0, reqStateDataType = 1'b0;
  wire logic [31:0] avsReadData, memRspData;
  wire logic avsWaitRequest, irq, reqReady, respValid, respGlobal, respDataType, respLlc;
  wire logic respMlc, respPageFault, respTableError, respDenied, memRdValid, memRdReady;
  wire logic memRdGlobal, memRspValid;
  wire logic [39:0] respAddr, memRdAddr;
  wire logic [46:0] seen = {respAddr, respGlobal, respDataType, respLlc, respMlc,
    respPageFault, respTableError, respDenied};
  tlpt_note_t notes[$];
  tlpt_note_t note;
  integer seed = 11;
  integer miscompares = 0, totalChecks = 0, cycles = 0;
  always #2 clk = ~clk;
  always @(posedge clk) respReady <= 1'($random(seed));
  tlpt_translate dut (.clk, .rst, .avsAddress, .avsRead, .avsWrite, .avsWriteData, .avsByteEnable,
    .avsReadData, .avsWaitRequest, .irq, .reqValid, .reqReady, .reqAddr, .reqWrite, .reqCpuRead,
    .reqMemIfCmd, .reqGlobal, .reqPrivSource, .reqStateDataType, .respValid, .respReady, .respAddr,
    .respGlobal, .respDataType, .respLlc, .respMlc, .respPageFault, .respTableError, .respDenied,
    .memRdValid, .memRdReady, .memRdAddr, .memRdGlobal, .memRspValid, .memRspData);
  tlpt_mem_model mem (.clk, .rst, .memRdValid, .memRdReady, .memRdAddr, .memRdGlobal,
    .memRspValid, .memRspData);
  task automatic check(input logic [46:0] got, input logic [46:0] exp);
    totalChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic testDone();
    $display("checks %0d mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic avs(input logic w, input logic [4:0] a, input logic [31:0] d,
      input logic [3:0] be, output logic [31:0] q);
    avsAddress <= a;
    avsWrite <= w;
    avsRead <= !w;
    avsWriteData <= d;
    avsByteEnable <= be;
    do @(posedge clk); while (avsWaitRequest);
    q = avsReadData;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    avs(1'b1, a, d, be, q);
  endtask
  task automatic rdChk(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    avs(1'b0, a, 32'h0, 4'hf, q);
    check({15'h0, q}, {15'h0, e});
  endtask
  task automatic irqChk(input logic e);
    @(negedge clk);
    check({46'h0, irq}, {46'h0, e});
    @(posedge clk);
  endtask
  // Flags are {write, cpu read, command, global, privileged, state data type}
  task automatic send(input logic [31:0] a, input logic [5:0] f, input logic [46:0] e, m);
    {reqWrite, reqCpuRead, reqMemIfCmd, reqGlobal, reqPrivSource, reqStateDataType} <= f;
    reqAddr <= a;
    reqValid <= 1'b1;
    do @(posedge clk); while (!reqReady);
    notes.push_back('{e, m});
    reqValid <= 1'b0;
    while (notes.size() != 0) @(posedge clk);
  endtask
  function automatic logic [46:0] walk(input logic [31:0] va, directory_entry, table_entry, input logic [5:0] f);
    logic [39:0] pa;
    pa = directory_entry[1] ? {table_entry[11:4], table_entry[31:15], va[14:0]} : {table_entry[11:4], table_entry[31:12], va[11:0]};
    return {pa, 1'b0, f[5] & (table_entry[3] | f[0]), table_entry[2], table_entry[2] & table_entry[1], 1'b0, !table_entry[0] & !f[4], 1'b0};
  endfunction
  always @(posedge clk) begin
    if (respValid && respReady) begin
      if (notes.size() == 0) begin
        check(47'h0, 47'h1);
      end else begin
        note = notes.pop_front();
        check(seen & note.m, note.v & note.m);
      end
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      testDone();
    end
  end
  // ----------
  // Main sequence
  // ----------
  initial begin
    logic [31:0] va, table_entry;
    logic [5:0] f;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdChk(`TLPT_REG_CTRL, `TLPT_CTRL_RESET);
    rdChk(`TLPT_REG_MASK, 32'h0);
    wr(5'h14, 32'hffff_ffff, 4'hf);
    rdChk(5'h14, 32'h0);
    wr(`TLPT_REG_DIR_BASE, 32'h0001_0000, 4'hf);
    rdChk(`TLPT_REG_DIR_BASE, 32'h0001_0000);
    va = $random(seed);
    send(va, 6'h21, {8'h00, va, 7'h60}, BYP);
    wr(`TLPT_REG_CTRL, 32'h1, 4'hf);
    for (int i = 0; i < 4; i++) begin
      va = $random(seed);
      f = {3'b001, i[1:0], 1'b0};
      if (i == 2)
        send(va, f, 47'h1, BYP & ~47'h40);
      else
        send(va, f, {8'h00, va, 7'h40}, BYP);
    end
    // Reserved bits set in the 4KB directory entry must not disturb the walk
    mem.words[40'h1_0004] = 32'h0002_001d;
    mem.words[40'h1_0008] = 32'h0003_0003;
    for (int k = 0; k < 4; k++) begin
      table_entry = $random(seed);
      table_entry[11:0] = {8'h00, table_entry[3], k[1:0], 1'b1};
      mem.words[40'h01_0002_0000 + 4 * k] = table_entry;
      for (int j = 0; j < 2; j++) begin
        va = {10'd1, k[9:0], 12'h0} | (32'($random(seed)) & 32'hfff);
        f = {j[0], 4'h0, 1'($random(seed))};
        send(va, f, walk(va, 32'h0002_001d, table_entry, f), ALL);
      end
    end
    table_entry = $random(seed) & 32'hffff_8000 | 32'h37;
    mem.words[40'h3_0020] = table_entry;
    mem.words[40'h3_0034] = 32'hffff_fffe;
    for (int n = 13; n > 8; n -= 4) begin
      va = {10'd2, 10'(n), 12'h0} | (32'($random(seed)) & 32'hfff);
      send(va, 6'h0, walk(va, 32'h0003_0003, table_entry, 6'h0), ALL);
    end
    va = {10'd3, 22'h0} | (32'($random(seed)) & 32'h3f_ffff);
    send(va, 6'h20, 47'h4, FLG);
    mem.words[40'h01_0002_0014] = 32'habcd_e004;
    va = {10'd1, 10'd5, 12'h0} | (32'($random(seed)) & 32'hfff);
    send(va, 6'h20, 47'h2, FLG);
    send(va, 6'h10, walk(va, 32'h0002_001d, 32'habcd_e004, 6'h10), ALL);
    rdChk(`TLPT_REG_STATUS, 32'h7);
    rdChk(`TLPT_REG_FAULT_ADDR, va);
    irqChk(1'b0);
    wr(`TLPT_REG_MASK, 32'h2, 4'h0);
    rdChk(`TLPT_REG_MASK, 32'h0);
    wr(`TLPT_REG_MASK, 32'h2, 4'h1);
    irqChk(1'b1);
    wr(`TLPT_REG_STATUS, 32'h2, 4'hf);
    irqChk(1'b0);
    rdChk(`TLPT_REG_STATUS, 32'h5);
    wr(`TLPT_REG_CTRL, 32'h0, 4'hf);
    send(va, 6'h20, {8'h00, va, 7'h40}, BYP);
    testDone();
  end
endmodule
bind tlpt_translate tlpt_translate_checker chk (.clk, .rst, .reqValid, .reqReady, .reqAddr,
  .reqCpuRead, .reqMemIfCmd, .reqGlobal, .reqPrivSource, .respValid, .respAddr, .respGlobal,
  .respLlc, .respMlc, .respPageFault, .respTableError, .respDenied, .memRdValid, .memRdReady,
  .memRdAddr, .memRdGlobal, .memRspValid, .memRspData);
`default_nettype wire
